// ===== verilog/sram_pkg.sv
package sram_pkg;
  // Data and address widths
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = LANE_W * LANES;
  localparam int ADDR_W = 18;
  localparam int FIFO_DEPTH = 16;
  // Burst counter geometry
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_LAST = 2'h3;
  // Mode pin defaults (pull-up on bypass, pull-down on sleep)
  localparam logic BYPASS_DEFAULT = 1'b1;
  localparam logic SLEEP_DEFAULT = 1'b0;
  // Cycle kinds
  typedef enum logic [1:0] {
    CYC_IDLE = 2'h0,
    CYC_READ = 2'h1,
    CYC_WRITE = 2'h3
  } cyc_t;
endpackage

// ===== verilog/rd_link_if.sv
`timescale 1ns/10ps
// Read data path from array to read data buffer
interface rd_link_if #(parameter int W = 36) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

// ===== verilog/sram_array.sv
`timescale 1ns/10ps
// Small memory with registered read data and byte-lane writes
module sram_array #(
  parameter int AW = 6,
  parameter int LW = 9,
  parameter int NL = 4
) (
  input wire logic clk,
  input wire logic [AW-1:0] addr,
  input wire logic [NL-1:0] lane_we,
  input wire logic [NL*LW-1:0] wdata,
  input wire logic rd,
  output logic [NL*LW-1:0] rdata
);
  logic [NL*LW-1:0] mem [2**AW];

  // Per-lane write, read data registered
  always_ff @(posedge clk) begin
    for (int i = 0; i < NL; i++) begin
      if (lane_we[i]) begin
        mem[addr][i*LW +: LW] <= wdata[i*LW +: LW];
      end
    end
    if (rd) begin
      rdata <= mem[addr];
    end
  end
endmodule

// ===== verilog/sync_fifo.sv
`timescale 1ns/10ps
// FIFO with valid/ready on both sides
module sync_fifo #(
  parameter int W = 36,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic flush,
  rd_link_if.snk in,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW:0] wp;
    logic [PW:0] rp;
  } fifo_state_t;
  fifo_state_t st;
  fifo_state_t next_st;
  logic [W-1:0] mem [DEPTH];
  logic full;
  logic push;
  logic pop;

  // Full when pointers differ only in wrap bit
  assign full = (st.wp[PW] != st.rp[PW]) &&
                (st.wp[PW-1:0] == st.rp[PW-1:0]);
  assign out_valid = (st.wp != st.rp);
  assign in.ready = !full;
  assign push = in.valid && !full;
  assign pop = out_valid && out_ready;
  assign out_data = mem[st.rp[PW-1:0]];

  // Storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[st.wp[PW-1:0]] <= in.data;
    end
  end

  // Pointer update; flush drops stale data
  always_comb begin
    next_st = st;
    if (flush) begin
      next_st.wp = '0;
      next_st.rp = '0;
    end else begin
      if (push) begin
        next_st.wp = st.wp + 1'b1;
      end
      if (pop) begin
        next_st.rp = st.rp + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule

// ===== verilog/sync_burst_sram_control.sv
`timescale 1ns/10ps
// Contract
// RQ1: Enables false and a strobe low deselect; lane-a high: controller only
// RQ2: Enabled processor strobe, or controller strobe without store, reads
// RQ3: Enabled controller strobe with store starts write at external address
// RQ4: Both strobes inactive and step low reads next burst address
// RQ5: Both strobes inactive, step low, store true writes next address
// RQ6: Inactive strobes with step high repeat at current address
// RQ7: Store false only when all-byte write and byte gate both high
// RQ8: Byte gate low writes only lanes whose lane inputs are low
// RQ9: Third and fourth lanes exist only in wide configurations
// RQ10: Read cycles drive all byte lanes
// RQ11: Write cycles keep all byte lanes high impedance
// RQ12: Output enable high disables drivers at once, unclocked
// RQ13: Output enable low only enables drivers read logic activated
// RQ14: Two-bit counter counts linear or interleaved, wraps on fifth clock
// RQ15: Unconnected bypass means pipeline; unconnected sleep means active
// RQ16: Dummy read advances burst counter like a normal read
// RQ17: Controller may use dummy reads to go from read to write
// RQ18: Controller holds output enable high long enough before such writes
// RQ19: Controller may tie strobes for simple non-burst operation
// RQ20: Controller may tie processor strobe high, step low for bursts
// RQ21: Burst order select low linear, high interleaved
// RQ22: Bypass low flow-through, high pipeline through output register
// RQ23: Sleep high enters standby and retains contents
// RQ24: All-byte write low writes every lane
// RQ25: Pipeline mode delivers read data one clock later
module sync_burst_sram_control #(
  parameter int LANES = sram_pkg::LANES,
  parameter int LANE_W = sram_pkg::LANE_W,
  parameter int AW = 6,
  parameter int FIFO_DEPTH = sram_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [AW-1:0] addr,
  input wire logic chip_enable_low_a,
  input wire logic chip_enable_high,
  input wire logic chip_enable_low_b,
  input wire logic processor_address_strobe,
  input wire logic controller_address_strobe,
  input wire logic burst_step,
  input wire logic all_byte_write,
  input wire logic byte_write_gate,
  input wire logic [LANES-1:0] lane_write_n,
  input wire logic output_enable_n,
  input wire logic burst_order_select,
  input wire logic output_register_bypass,
  input wire logic bypass_connected,
  input wire logic sleep_request,
  input wire logic sleep_connected,
  input wire logic [LANES*LANE_W-1:0] dq_in,
  output logic [LANES*LANE_W-1:0] dq_out,
  output logic [LANES-1:0] dq_oe,
  output logic rd_data_valid,
  output logic sleeping
);
  localparam int DW = LANES * LANE_W;

  typedef struct packed {
    logic [AW-1:0] base;
    logic [1:0] load;
    logic [1:0] step;
    sram_pkg::cyc_t cyc;
    logic rd_stage;
    logic drive;
    logic [DW-1:0] out_reg;
    logic out_valid;
  } ctl_state_t;

  ctl_state_t st;
  ctl_state_t next_st;

  // Resolved mode pins with pull defaults
  logic pipe_mode;
  logic sleep_mode;
  logic interleave;
  logic enables_true;
  logic strobes_idle;
  logic store;
  logic begin_read;
  logic begin_write;
  logic deselect;
  logic cont;
  logic [1:0] cur_low;
  logic [AW-1:0] cur_addr;
  logic [AW-1:0] arr_addr;
  logic [LANES-1:0] lane_en;
  logic [LANES-1:0] lane_we;
  logic arr_rd;
  logic [DW-1:0] arr_q;
  logic [DW-1:0] fifo_q;
  logic fifo_valid;
  logic fifo_pop;

  // Burst address: linear adds, interleaved xors
  function automatic logic [1:0] burst_addr(input logic [1:0] ld,
                                            input logic [1:0] cnt,
                                            input logic ilv);
    logic [1:0] r;
    r = ilv ? (ld ^ cnt) : 2'(ld + cnt);
    return r;
  endfunction

  // RQ15 pull defaults
  assign pipe_mode = bypass_connected ? output_register_bypass
                                      : sram_pkg::BYPASS_DEFAULT;
  assign sleep_mode = sleep_connected ? sleep_request
                                      : sram_pkg::SLEEP_DEFAULT;
  // RQ21 order select
  assign interleave = burst_order_select;
  assign sleeping = sleep_mode;

  assign enables_true = !chip_enable_low_a && chip_enable_high &&
                        !chip_enable_low_b;
  // RQ4 inactive strobe condition
  assign strobes_idle = controller_address_strobe &&
                        (processor_address_strobe || chip_enable_low_a);
  // RQ7 store flag
  assign store = !(all_byte_write && byte_write_gate);
  // RQ1 deselect decode
  assign deselect = !enables_true && (!controller_address_strobe ||
                    (!processor_address_strobe && !chip_enable_low_a));
  // RQ2 read start
  assign begin_read = enables_true && (!processor_address_strobe ||
                      (!controller_address_strobe && !store));
  // RQ3 write start
  assign begin_write = enables_true && processor_address_strobe &&
                       !controller_address_strobe && store;
  assign cont = strobes_idle && st.cyc != sram_pkg::CYC_IDLE;

  // RQ8 RQ9 RQ24 lane write gating; upper lanes absent if LANES < 4
  always_comb begin
    lane_en = '0;
    if (!all_byte_write) begin
      lane_en = '1;
    end else if (!byte_write_gate) begin
      lane_en = ~lane_write_n;
    end
  end

  // Address for this cycle; next step only when burst_step is low
  always_comb begin
    cur_low = burst_addr(st.load, st.step, interleave);
    cur_addr = st.base;
    if (begin_read || begin_write) begin
      cur_addr = addr;
    end else if (cont && !burst_step) begin
      // RQ14 next burst address
      cur_addr[1:0] = burst_addr(st.load, 2'(st.step + 2'h1), interleave);
    end else begin
      cur_addr[1:0] = cur_low;
    end
  end

  // RQ23 sleep blocks access, contents held
  assign arr_addr = cur_addr;
  assign arr_rd = !sleep_mode && !deselect && (begin_read ||
                  (cont && !store) || (cont && !begin_write &&
                  st.cyc == sram_pkg::CYC_READ && !store));
  // RQ5 RQ6 writes at next or current address
  assign lane_we = (!sleep_mode && !deselect && (begin_write ||
                   (cont && store))) ? lane_en : '0;

  sram_array #(
    .AW(AW),
    .LW(LANE_W),
    .NL(LANES)
  ) u_array (
    .clk(clk),
    .addr(arr_addr),
    .lane_we(lane_we),
    .wdata(dq_in),
    .rd(arr_rd),
    .rdata(arr_q)
  );

  rd_link_if #(.W(DW)) link ();
  assign link.data = arr_q;
  assign link.valid = st.rd_stage;

  // Read data buffer drained by output stage
  sync_fifo #(
    .W(DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .flush(deselect),
    .in(link),
    .out_data(fifo_q),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Output stage pops one word per read-data slot
  assign fifo_pop = fifo_valid;

  // Sequencer: burst state, counter and output register
  always_comb begin
    next_st = st;
    next_st.rd_stage = arr_rd && !sleep_mode;
    next_st.out_valid = 1'b0;
    if (sleep_mode) begin
      next_st.drive = 1'b0;
    end else if (deselect) begin
      next_st.cyc = sram_pkg::CYC_IDLE;
      next_st.drive = 1'b0;
    end else if (begin_read || begin_write) begin
      next_st.base = addr;
      next_st.load = addr[1:0];
      next_st.step = 2'h0;
      next_st.cyc = begin_write ? sram_pkg::CYC_WRITE : sram_pkg::CYC_READ;
      // RQ10 RQ11 only reads drive
      next_st.drive = begin_read;
    end else if (cont) begin
      // RQ16 dummy reads advance too; output enable not consulted
      if (!burst_step) begin
        next_st.step = 2'(st.step + 2'h1);
      end
      // RQ6 step high holds counter
      next_st.cyc = store ? sram_pkg::CYC_WRITE : sram_pkg::CYC_READ;
      // RQ11 writes float the bus
      next_st.drive = !store;
    end
    // RQ22 RQ25 pipeline registers popped word
    // A captured deselect or write drops it, so outputs never lag off
    if (fifo_pop) begin
      next_st.out_reg = fifo_q;
      next_st.out_valid = next_st.drive;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Flow-through shows buffer head word; pipeline shows registered word
  always_comb begin
    dq_out = st.out_reg;
    rd_data_valid = st.out_valid;
    if (!pipe_mode) begin
      dq_out = fifo_q;
      // Head word only counts while the read logic still drives
      rd_data_valid = fifo_valid && st.drive;
    end
  end

  // RQ12 RQ13 output enable gates only active read drivers
  // Follows the word slot, so flow-through drives in its own cycle
  assign dq_oe = (rd_data_valid && st.drive && !output_enable_n &&
                  !sleep_mode) ? '1 : '0;
endmodule

// ===== tb/bus_master_model.sv
`timescale 1ns/10ps
// Controller model; pins move just after the falling edge
module bus_master_model (
  input wire logic clk,
  output logic [5:0] addr,
  output logic [5:0] ctl_n,
  output logic [3:0] lane_n,
  output logic [35:0] data
);
  // Start as a deselect so nothing is read before the first command
  initial begin
    addr = 6'h00;
    ctl_n = 6'h37;
    lane_n = 4'hF;
    data = 36'h000000000;
  end
  // one command a cycle, held to the next edge
  task automatic cyc(input logic [5:0] c, input logic [5:0] a,
                     input logic [3:0] ln, input logic [35:0] d);
    @(negedge clk);
    ctl_n = c;
    addr = a;
    lane_n = ln;
    // Undriven bus flips so a stale word never looks valid
    data = (c[1] && c[0]) ? ~data : d;
  endtask
endmodule

// ===== tb/sram_ctrl_props.sv
`timescale 1ns/10ps
// Port checks on the burst control block
module sram_ctrl_props #(
  parameter int LANES = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_enable_low_a,
  input wire logic chip_enable_high,
  input wire logic chip_enable_low_b,
  input wire logic processor_address_strobe,
  input wire logic controller_address_strobe,
  input wire logic all_byte_write,
  input wire logic byte_write_gate,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic sleep_connected,
  input wire logic [LANES-1:0] dq_oe,
  input wire logic rd_data_valid,
  input wire logic sleeping
);
  logic en;
  logic st;
  logic desel;
  logic wr;
  // Command decode as the device samples it
  assign en = !chip_enable_low_a && chip_enable_high && !chip_enable_low_b;
  assign st = !(all_byte_write && byte_write_gate);
  assign desel = !en && (!controller_address_strobe ||
    (!processor_address_strobe && !chip_enable_low_a));
  assign wr = st && ((en && processor_address_strobe &&
    !controller_address_strobe) || (controller_address_strobe &&
    (processor_address_strobe || chip_enable_low_a)));
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_oe_off;
    output_enable_n |-> dq_oe == '0;
  endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("drive with oe high");
  property p_whole;
    dq_oe == '0 || dq_oe == '1;
  endproperty
  a_whole: assert property (p_whole) else $error("partial lanes");
  property p_only_read;
    dq_oe != '0 |-> rd_data_valid;
  endproperty
  a_only_read: assert property (p_only_read)
    else $error("drive no data");
  property p_read_drives;
    rd_data_valid && !output_enable_n && !sleeping |-> dq_oe == '1;
  endproperty
  a_read_drives: assert property (p_read_drives)
    else $error("read undriven");
  property p_desel;
    desel [*4] |-> !rd_data_valid && dq_oe == '0;
  endproperty
  a_desel: assert property (p_desel) else $error("deselect not quiet");
  property p_wr_quiet;
    wr [*4] |-> dq_oe == '0;
  endproperty
  a_wr_quiet: assert property (p_wr_quiet)
    else $error("drive in write");
  property p_slp_def;
    !sleep_connected [*3] |-> !sleeping;
  endproperty
  a_slp_def: assert property (p_slp_def) else $error("floating sleep");
  property p_slp_on;
    (sleep_connected && sleep_request) [*3] |-> sleeping;
  endproperty
  a_slp_on: assert property (p_slp_on) else $error("no standby");
  // Main scenarios reached
  c_write: cover property (wr [*4]);
  c_read: cover property (rd_data_valid && dq_oe == '1);
  c_sleep: cover property (sleeping);
endmodule
bind sync_burst_sram_control sram_ctrl_props #(.LANES(LANES)) u_props (
  .clk(clk), .reset_n(reset_n), .chip_enable_low_a(chip_enable_low_a),
  .chip_enable_high(chip_enable_high),
  .chip_enable_low_b(chip_enable_low_b),
  .processor_address_strobe(processor_address_strobe),
  .controller_address_strobe(controller_address_strobe),
  .all_byte_write(all_byte_write), .byte_write_gate(byte_write_gate),
  .output_enable_n(output_enable_n), .sleep_request(sleep_request),
  .sleep_connected(sleep_connected), .dq_oe(dq_oe),
  .rd_data_valid(rd_data_valid), .sleeping(sleeping));

// ===== tb/sync_burst_sram_control_test.sv
`timescale 1ns/10ps
// Bench for the burst control block
module sync_burst_sram_control_test;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic order = 1'b0;
  logic byp = 1'b0;
  logic byp_con = 1'b1;
  logic slp = 1'b0;
  logic slp_con = 1'b1;
  logic oe_n = 1'b0;
  logic [5:0] addr;
  logic [5:0] ctl_n;
  logic [3:0] lane_n;
  logic [35:0] data;
  logic [35:0] dq_out;
  logic [3:0] dq_oe;
  logic valid;
  logic sleeping;
  logic [35:0] got[$];
  int errors = 0;
  int tests_run = 0;
  int ncyc = 0;
  int first = 0;
  int f;
  int p;
  int d;
  always #25 clk = ~clk;
  bus_master_model bm (.clk(clk), .addr(addr), .ctl_n(ctl_n),
    .lane_n(lane_n), .data(data));
  sync_burst_sram_control dut (
    .clk(clk), .reset_n(reset_n), .addr(addr),
    .chip_enable_low_a(ctl_n[5]), .chip_enable_high(1'b1),
    .chip_enable_low_b(1'b0), .processor_address_strobe(ctl_n[4]),
    .controller_address_strobe(ctl_n[3]), .burst_step(ctl_n[2]),
    .all_byte_write(ctl_n[1]), .byte_write_gate(ctl_n[0]),
    .lane_write_n(lane_n), .output_enable_n(oe_n),
    .burst_order_select(order), .output_register_bypass(byp),
    .bypass_connected(byp_con), .sleep_request(slp),
    .sleep_connected(slp_con), .dq_in(data), .dq_out(dq_out),
    .dq_oe(dq_oe), .rd_data_valid(valid), .sleeping(sleeping));
  // Collect read words; a hang counts as a mismatch
  always @(posedge clk) begin
    ncyc++;
    if (valid === 1'b1) begin
      if (got.size() == 0) first = ncyc;
      got.push_back(dq_out);
    end
    if (ncyc > 2000) begin
      errors++;
      test_done();
    end
  end
  function automatic logic [35:0] pat(input int i);
    return 36'h5A5A5A5A0 + 36'(i);
  endfunction
  task automatic chk(input string what, input logic [35:0] exp,
                     input logic [35:0] seen);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) bm.cyc(6'h37, 6'h00, 4'hF, 36'h0);
  endtask
  // Start, three steps, then suspend so late words still land
  task automatic rd4(input logic [5:0] c, input logic [5:0] a);
    got.delete();
    bm.cyc(c, a, 4'hF, 36'h0);
    repeat (3) bm.cyc(6'h1B, 6'h00, 4'hF, 36'h0);
    repeat (4) bm.cyc(6'h1F, 6'h00, 4'hF, 36'h0);
    idle(4);
  endtask
  task automatic lat(input logic b, input logic con, output int n);
    byp = b;
    byp_con = con;
    idle(4);
    got.delete();
    bm.cyc(6'h0F, 6'h05, 4'hF, 36'h0);
    n = ncyc;
    repeat (6) bm.cyc(6'h1F, 6'h00, 4'hF, 36'h0);
    n = first - n;
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    idle(2);
    // Write burst from A[1:0]=2 wraps, then linear read from 0
    bm.cyc(6'h15, 6'h06, 4'hF, pat(0));
    for (int i = 1; i < 4; i++) bm.cyc(6'h19, 6'h00, 4'hF, pat(i));
    idle(4);
    rd4(6'h0F, 6'h04);
    for (int i = 0; i < 4; i++) begin
      chk("linear", pat((i + 2) % 4), got[i]);
    end
    $display("linear burst done");
    // Interleaved read started by the controller strobe
    order = 1'b1;
    rd4(6'h17, 6'h05);
    for (int i = 0; i < 4; i++) chk("interleave", pat(3 - i), got[i]);
    order = 1'b0;
    $display("interleaved burst done");
    // Lane b alone, then no lanes at all
    bm.cyc(6'h16, 6'h04, 4'hD, 36'hFFFFFFFFF);
    bm.cyc(6'h16, 6'h05, 4'hF, 36'hFFFFFFFFF);
    idle(4);
    rd4(6'h0F, 6'h04);
    chk("lane b", pat(2) | 36'h00003FE00, got[0]);
    chk("no lane", pat(3), got[1]);
    $display("byte lanes done");
    // Two dummy reads must still step the burst address to 6
    oe_n = 1'b1;
    got.delete();
    bm.cyc(6'h0F, 6'h04, 4'hF, 36'h0);
    bm.cyc(6'h1B, 6'h00, 4'hF, 36'h0);
    bm.cyc(6'h1B, 6'h00, 4'hF, 36'h0);
    oe_n = 1'b0;
    repeat (4) bm.cyc(6'h1F, 6'h00, 4'hF, 36'h0);
    chk("dummy step", pat(0), got[got.size() - 1]);
    idle(4);
    $display("dummy read done");
    // Output register adds one cycle; floating pin means pipeline
    lat(1'b0, 1'b1, f);
    lat(1'b1, 1'b1, p);
    lat(1'b0, 1'b0, d);
    chk("pipe lag", 36'(f + 1), 36'(p));
    chk("float bypass", 36'(p), 36'(d));
    $display("latency done");
    // Standby blocks reads; floating sleep pin means active
    slp = 1'b1;
    idle(4);
    got.delete();
    bm.cyc(6'h0F, 6'h04, 4'hF, 36'h0);
    idle(4);
    chk("asleep", 36'h1, {35'h0, sleeping});
    chk("sleep read", 36'h0, 36'(got.size()));
    slp_con = 1'b0;
    idle(4);
    chk("awake", 36'h0, {35'h0, sleeping});
    $display("sleep done");
    test_done();
  end
endmodule
